// [rtl/serial_adapter_pkg.sv]
// Constants shared by the serial adapter host-side logic and its FIFO.
package serial_adapter_pkg;
    // Register select codes {register_select_high, register_select_low}.
    localparam logic [1:0] SEL_DATA = 2'h0;
    localparam logic [1:0] SEL_STATUS = 2'h1;

    // Status register field positions.
    localparam int unsigned ST_IRQ = 7;
    localparam int unsigned ST_DSR = 6;
    localparam int unsigned ST_DCD = 5;
    localparam int unsigned ST_TXE = 4;
    localparam int unsigned ST_RXF = 3;
    localparam int unsigned ST_OVR = 2;
    localparam int unsigned ST_FE = 1;
    localparam int unsigned ST_PE = 0;

    // Values after hardware reset.
    localparam logic TXE_RESET = 1'b1;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic MODEM_RESET = 1'b1;

    // Transmit interrupt control code that enables the transmit interrupt.
    localparam logic [1:0] TIC_TX_IRQ = 2'h1;

    // Word length codes and the matching data masks.
    localparam logic [1:0] WL_8 = 2'h0;
    localparam logic [1:0] WL_7 = 2'h1;
    localparam logic [1:0] WL_6 = 2'h2;
    localparam logic [7:0] MASK_8 = 8'hff;
    localparam logic [7:0] MASK_7 = 8'h7f;
    localparam logic [7:0] MASK_6 = 8'h3f;
    localparam logic [7:0] MASK_5 = 8'h1f;

    // Transmit-empty flag lag: one sixth of a bit time at the top rate.
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS = 52083;
    localparam int TX_LAG_NS = BIT_TIME_NS / 6;
    localparam int TX_LAG_CYCLES = TX_LAG_NS / CLK_PERIOD_NS;
    localparam logic [11:0] TX_LAG_LOAD = 12'(TX_LAG_CYCLES - 1);
    localparam logic [11:0] LAG_ZERO = 12'h000;

    // Receive FIFO shape: error bits travel with each character.
    localparam int RX_FIFO_WIDTH = 10;
    localparam int RX_FIFO_DEPTH = 16;

    function automatic logic [7:0] word_mask(input logic [1:0] wl);
        unique case (wl)
            WL_8: word_mask = MASK_8;
            WL_7: word_mask = MASK_7;
            WL_6: word_mask = MASK_6;
            default: word_mask = MASK_5;
        endcase
    endfunction
endpackage

// [rtl/rx_fifo.sv]
// Parameterised FIFO with registered output stage and registered ready.
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    // The output stage refills whenever it is empty or being drained.
    assign pop = (count_q != '0) && (!out_valid || out_ready);

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + (AW+1)'(1);
        end else if (pop && !push) begin
            count_d = count_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            count_q <= count_d;
            in_ready <= count_d < (AW+1)'(DEPTH);
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
                out_data <= mem_q[rd_q];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/serial_adapter.sv]
// Host-side bus buffer, data holding registers and status of the adapter.
`timescale 1ns/1ps
`default_nettype none
module serial_adapter (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic phase2,
    input wire logic chip_select,
    input wire logic read_not_write,
    input wire logic register_select_low,
    input wire logic register_select_high,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic irq_n,
    input wire logic data_set_ready_n,
    input wire logic carrier_detect_n,
    input wire logic [1:0] word_length,
    input wire logic receive_irq_disable,
    input wire logic terminal_ready,
    input wire logic [1:0] transmit_irq_control,
    output logic request_to_send_n,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_take,
    input wire logic [7:0] rx_data,
    input wire logic rx_frame_error,
    input wire logic rx_parity_error,
    input wire logic rx_valid,
    output logic rx_ready
);
    import serial_adapter_pkg::*;

    logic [1:0] rst_q;
    logic rst_n;
    logic [14:0] pin_m_q;
    logic [14:0] pin_s_q;
    logic [12:0] bus_prev_q;
    logic p2_s, cs_s, rw_s;
    logic [1:0] rs_s;
    logic bus_end, acc_rd, acc_wr;
    logic [1:0] acc_sel;
    logic wr_tx_ev, wr_prog_rst, rd_rx_ev, rd_status_ev;
    logic [7:0] transmit_holding_q;
    logic tx_full_q, tx_empty_q;
    logic [11:0] lag_cnt_q;
    logic tx_empty_rise;
    logic [7:0] receive_holding_q;
    logic rx_full_q, ovr_q, fe_q, pe_q;
    logic fifo_valid, fifo_ready, rx_load;
    logic [RX_FIFO_WIDTH-1:0] fifo_out;
    logic dsr_q, dcd_q, modem_lock_q, modem_change;
    logic [2:0] modem_init_q;
    logic rx_irq_en, tx_irq_en, irq_set, irq_q;
    logic [7:0] status_word;

    // Reset is released through two flip-flops.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Bus and modem pins pass two flip-flops before any logic.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_m_q <= '0;
            pin_s_q <= '0;
            bus_prev_q <= '0;
        end else begin
            pin_m_q <= {data_set_ready_n, carrier_detect_n, phase2,
                        chip_select, read_not_write, register_select_high,
                        register_select_low, data_in};
            pin_s_q <= pin_m_q;
            bus_prev_q <= pin_s_q[12:0];
        end
    end
    assign p2_s = pin_s_q[12];
    assign cs_s = pin_s_q[11];
    assign rw_s = pin_s_q[10];
    assign rs_s = pin_s_q[9:8];

    // phase gated transfers.
    // An access commits as phase two falls, using the last selected sample.
    assign bus_end = bus_prev_q[12] && !p2_s && bus_prev_q[11];
    assign acc_rd = bus_end && bus_prev_q[10];
    assign acc_wr = bus_end && !bus_prev_q[10];
    assign acc_sel = bus_prev_q[9:8];
    assign wr_tx_ev = acc_wr && acc_sel == SEL_DATA;
    assign wr_prog_rst = acc_wr && acc_sel == SEL_STATUS;
    assign rd_rx_ev = acc_rd && acc_sel == SEL_DATA;
    assign rd_status_ev = acc_rd && acc_sel == SEL_STATUS;

    assign status_word = {irq_q, dsr_q, dcd_q, tx_empty_q,
                          rx_full_q, ovr_q, fe_q, pe_q};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= BYTE_RESET;
            data_oe <= 1'b0;
        end else begin
            data_oe <= p2_s && cs_s && rw_s;
            unique case (rs_s)
                SEL_DATA: data_out <= receive_holding_q;
                SEL_STATUS: data_out <= status_word;
                default: data_out <= BYTE_RESET;
            endcase
        end
    end

    // bits above the word length are dropped when data is stored.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_holding_q <= BYTE_RESET;
            tx_full_q <= 1'b0;
        end else begin
            if (wr_tx_ev) begin
                transmit_holding_q <= bus_prev_q[7:0] & word_mask(word_length);
            end
            if (wr_tx_ev) begin
                tx_full_q <= 1'b1;
            end else if (tx_take && tx_full_q) begin
                tx_full_q <= 1'b0;
            end
        end
    end
    assign tx_data = transmit_holding_q;
    assign tx_valid = tx_full_q;

    // empty flag tracks transfer and host write.
    // the flag follows the real state after a lag count.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_empty_q <= TXE_RESET;
            lag_cnt_q <= TX_LAG_LOAD;
        end else if (tx_empty_q == tx_full_q) begin
            if (lag_cnt_q == LAG_ZERO) begin
                tx_empty_q <= !tx_full_q;
                lag_cnt_q <= TX_LAG_LOAD;
            end else begin
                lag_cnt_q <= lag_cnt_q - 12'h001;
            end
        end else begin
            lag_cnt_q <= TX_LAG_LOAD;
        end
    end
    assign tx_empty_rise = !tx_empty_q && tx_full_q == 1'b0
                           && lag_cnt_q == LAG_ZERO;

    // high bits zero, parity already removed by the shifter.
    rx_fifo #(
        .WIDTH(RX_FIFO_WIDTH),
        .DEPTH(RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(rx_valid),
        .in_ready(fifo_ready),
        .in_data({rx_frame_error, rx_parity_error,
                  rx_data & word_mask(word_length)}),
        .out_valid(fifo_valid),
        .out_ready(!rx_full_q || rd_rx_ev),
        .out_data(fifo_out)
    );
    assign rx_ready = fifo_ready;
    assign rx_load = fifo_valid && (!rx_full_q || rd_rx_ev);

    // full flag, a new load wins over a read.
    // error flags clear on read unless a new character lands.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            receive_holding_q <= BYTE_RESET;
            rx_full_q <= FLAG_RESET;
            fe_q <= FLAG_RESET;
            pe_q <= FLAG_RESET;
        end else if (rx_load) begin
            receive_holding_q <= fifo_out[7:0];
            rx_full_q <= 1'b1;
            fe_q <= fifo_out[9];
            pe_q <= fifo_out[8];
        end else if (rd_rx_ev) begin
            rx_full_q <= 1'b0;
            fe_q <= 1'b0;
            pe_q <= 1'b0;
        end
    end

    // program reset clears only overrun.
    // Overrun: a character arrives while the FIFO is full; set wins.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_q <= FLAG_RESET;
        end else if (rx_valid && !fifo_ready) begin
            ovr_q <= 1'b1;
        end else if (rd_rx_ev || wr_prog_rst) begin
            ovr_q <= 1'b0;
        end
    end

    // a change latches and locks until the status is read.
    // Levels are taken until the pin synchroniser holds real samples, so
    // no false change is seen right after reset.
    assign modem_change = modem_init_q[2] && !modem_lock_q
                          && {pin_s_q[14], pin_s_q[13]} != {dsr_q, dcd_q};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dsr_q <= MODEM_RESET;
            dcd_q <= MODEM_RESET;
            modem_lock_q <= 1'b0;
            modem_init_q <= 3'h0;
        end else begin
            modem_init_q <= {modem_init_q[1:0], 1'b1};
            if (!modem_init_q[2] || modem_change) begin
                dsr_q <= pin_s_q[14];
                dcd_q <= pin_s_q[13];
            end
            if (modem_change) begin
                modem_lock_q <= 1'b1;
            end else if (rd_status_ev) begin
                modem_lock_q <= 1'b0;
            end
        end
    end

    assign rx_irq_en = !receive_irq_disable && terminal_ready;
    assign tx_irq_en = transmit_irq_control == TIC_TX_IRQ;
    // error flags are not interrupt sources.
    // any enabled source among bits 3-6 sets the summary.
    assign irq_set = (rx_load && rx_irq_en) || (tx_empty_rise && tx_irq_en)
                     || modem_change;

    // summary sets on a source and clears on status read; set wins.
    // summary and the source flag set together.
    // the pin follows the summary bit.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= FLAG_RESET;
            irq_n <= 1'b1;
            request_to_send_n <= 1'b1;
        end else begin
            irq_q <= irq_set || (irq_q && !rd_status_ev);
            irq_n <= !(irq_set || (irq_q && !rd_status_ev));
            request_to_send_n <= transmit_irq_control == 2'h0;
        end
    end

    sequence host_wr_s;
        wr_tx_ev;
    endsequence
    sequence rx_read_s;
        rd_rx_ev && !rx_load;
    endsequence

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // stored byte matches masked bus data.
    tx_write_a: assert property (host_wr_s |=> tx_valid
        && tx_data == ($past(bus_prev_q[7:0]) & $past(word_mask(word_length))))
        else $error("transmit write not stored");
    read_drive_a: assert property (data_oe |->
        $past(p2_s) && $past(cs_s) && $past(rw_s))
        else $error("bus driven outside a read");
    irq_pin_a: assert property (irq_set |=> !irq_n)
        else $error("interrupt pin disagrees with summary");
    rx_summary_a: assert property (rx_load && rx_irq_en |=>
        irq_q && rx_full_q)
        else $error("receive interrupt not flagged");
    err_no_irq_a: assert property ($rose(irq_q) |->
        $past(rx_load || tx_empty_rise || modem_change))
        else $error("summary set without a source");
    rx_read_clr_a: assert property (rx_read_s |=>
        !rx_full_q && !fe_q && !pe_q)
        else $error("receive read left flags set");
    tx_lag_a: assert property ($changed(tx_empty_q) |->
        $past(lag_cnt_q) == LAG_ZERO && tx_empty_q == !$past(tx_full_q))
        else $error("transmit empty flag changed early");
    modem_hold_a: assert property (modem_lock_q && !rd_status_ev |=>
        $stable({dsr_q, dcd_q}))
        else $error("modem bits moved while locked");
    status_clr_a: assert property (rd_status_ev && !irq_set |=>
        !irq_q)
        else $error("status read did not clear summary");
endmodule
`default_nettype wire

// [sim/host_bus_model.sv]
// Processor bus model that drives the adapter's register pins.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic sys_clk,
    output logic phase2,
    output logic chip_select,
    output logic read_not_write,
    output logic register_select_low,
    output logic register_select_high,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic rd_strobe,
    output logic [7:0] rd_byte
);
    initial begin
        phase2 = 1'b0;
        chip_select = 1'b0;
        read_not_write = 1'b1;
        {register_select_high, register_select_low} = 2'h0;
        data_in = 8'h00;
        rd_strobe = 1'b0;
        rd_byte = 8'h00;
    end

    // One bus cycle; pins stay put until phase two has fallen and settled.
    task automatic access(input logic rw, input logic cs,
            input logic [1:0] sel, input logic [7:0] wdata);
        @(negedge sys_clk);
        chip_select = cs;
        read_not_write = rw;
        {register_select_high, register_select_low} = sel;
        data_in = rw ? ~data_in : wdata;
        phase2 = 1'b1;
        repeat (5) @(negedge sys_clk);
        rd_byte = (data_oe === 1'b1) ? data_out : 8'hxx;
        rd_strobe = rw;
        phase2 = 1'b0;
        @(negedge sys_clk);
        rd_strobe = 1'b0;
        repeat (3) @(negedge sys_clk);
        chip_select = 1'b0;
        data_in = ~data_in;
        repeat (2) @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

// [sim/serial_adapter_tb.sv]
// Self-checking bench for the adapter's host registers and status.
`timescale 1ns/1ps
`default_nettype none
module serial_adapter_tb;
    import serial_adapter_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic phase2, chip_select, read_not_write;
    logic register_select_low, register_select_high;
    logic [7:0] data_in, data_out, tx_data, rd_byte, b;
    logic data_oe, irq_n, request_to_send_n, tx_valid, rx_ready, rd_strobe;
    logic data_set_ready_n = 1'b0;
    logic carrier_detect_n = 1'b1;
    logic [1:0] word_length = 2'h0;
    logic receive_irq_disable = 1'b1;
    logic terminal_ready = 1'b1;
    logic [1:0] transmit_irq_control = 2'h1;
    logic tx_take = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_frame_error = 1'b0;
    logic rx_parity_error = 1'b0;
    logic rx_valid = 1'b0;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] exp_q[$];
    string name_q[$];
    logic [7:0] fifo_q[$];

    always #5 sys_clk = ~sys_clk;

    serial_adapter u_dut (
        .sys_clk, .resetn, .phase2, .chip_select, .read_not_write,
        .register_select_low, .register_select_high, .data_in, .data_out,
        .data_oe, .irq_n, .data_set_ready_n, .carrier_detect_n,
        .word_length, .receive_irq_disable, .terminal_ready,
        .transmit_irq_control, .request_to_send_n, .tx_data, .tx_valid,
        .tx_take, .rx_data, .rx_frame_error, .rx_parity_error, .rx_valid,
        .rx_ready
    );

    host_bus_model u_host (
        .sys_clk, .phase2, .chip_select, .read_not_write,
        .register_select_low, .register_select_high, .data_in, .data_out,
        .data_oe, .rd_strobe, .rd_byte
    );

    task automatic check(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Notes the expected byte, then runs the read cycle.
    task automatic read_reg(input string what, input logic [1:0] sel,
            input logic [7:0] exp);
        name_q.push_back(what);
        exp_q.push_back(exp);
        u_host.access(1'b1, 1'b1, sel, 8'h00);
    endtask

    task automatic wait_irq(input logic lvl, input int n);
        for (int i = 0; i < n; i++) begin
            if (irq_n === lvl) break;
            @(negedge sys_clk);
        end
        check("irq_n", 8'(irq_n), 8'(lvl));
    endtask

    task automatic push_rx(input logic [7:0] d, input logic fe,
            input logic pe);
        @(negedge sys_clk);
        rx_data = d;
        rx_frame_error = fe;
        rx_parity_error = pe;
        rx_valid = 1'b1;
        @(negedge sys_clk);
        rx_valid = 1'b0;
    endtask

    always @(posedge sys_clk) begin
        if (rd_strobe) begin
            check(name_q.pop_front(), rd_byte, exp_q.pop_front());
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        void'($urandom(32'h5a72_370c));
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (5) @(negedge sys_clk);
        check("irq_n", 8'(irq_n), 8'h01);
        check("tx_valid", 8'(tx_valid), 8'h00);
        read_reg("status", SEL_STATUS, 8'h30);
        check("rts_n", 8'(request_to_send_n), 8'h00);
        // Every word length, each character taken straight away.
        for (int w = 0; w < 4; w++) begin
            word_length = 2'(w);
            b = 8'($urandom);
            u_host.access(1'b0, 1'b1, SEL_DATA, b);
            check("tx_valid", 8'(tx_valid), 8'h01);
            check("tx_data", tx_data, b & (8'hff >> w));
            tx_take = 1'b1;
            @(negedge sys_clk);
            tx_take = 1'b0;
            @(negedge sys_clk);
            check("tx_valid", 8'(tx_valid), 8'h00);
        end
        // Unselected and reserved accesses must leave the holding empty.
        u_host.access(1'b0, 1'b0, SEL_DATA, 8'h5a);
        u_host.access(1'b0, 1'b1, 2'h3, 8'ha5);
        check("tx_valid", 8'(tx_valid), 8'h00);
        read_reg("reserved", 2'h2, 8'h00);
        word_length = 2'h0;
        b = 8'($urandom);
        u_host.access(1'b0, 1'b1, SEL_DATA, b);
        read_reg("status", SEL_STATUS, 8'h30);
        repeat (880) @(negedge sys_clk);
        read_reg("status", SEL_STATUS, 8'h20);
        tx_take = 1'b1;
        @(negedge sys_clk);
        tx_take = 1'b0;
        repeat (800) @(negedge sys_clk);
        check("irq_n", 8'(irq_n), 8'h01);
        wait_irq(1'b0, 100);
        read_reg("status", SEL_STATUS, 8'hb0);
        wait_irq(1'b1, 5);
        // Receive with the interrupt enabled and both errors flagged.
        receive_irq_disable = 1'b0;
        word_length = 2'h1;
        b = 8'($urandom);
        push_rx(b, 1'b1, 1'b1);
        wait_irq(1'b0, 20);
        read_reg("status", SEL_STATUS, 8'hbb);
        read_reg("rx_holding", SEL_DATA, b & 8'h7f);
        read_reg("status", SEL_STATUS, 8'h30);
        receive_irq_disable = 1'b1;
        word_length = 2'h0;
        b = 8'($urandom);
        push_rx(b, 1'b0, 1'b0);
        repeat (20) @(negedge sys_clk);
        check("irq_n", 8'(irq_n), 8'h01);
        read_reg("status", SEL_STATUS, 8'h38);
        read_reg("rx_holding", SEL_DATA, b);
        // Receive interrupt stays off while terminal ready is 0.
        receive_irq_disable = 1'b0;
        terminal_ready = 1'b0;
        // Fill until refused; the refused character is an overrun.
        for (int i = 0; i < 40; i++) begin
            @(negedge sys_clk);
            rx_data = 8'($urandom);
            rx_valid = 1'b1;
            if (rx_ready !== 1'b1) break;
            fifo_q.push_back(rx_data);
        end
        @(negedge sys_clk);
        rx_valid = 1'b0;
        repeat (5) @(negedge sys_clk);
        // The holding register and the output stage hold two more.
        check("depth", 8'(fifo_q.size()), 8'(RX_FIFO_DEPTH + 2));
        check("irq_n", 8'(irq_n), 8'h01);
        read_reg("status", SEL_STATUS, 8'h3c);
        u_host.access(1'b0, 1'b1, SEL_STATUS, 8'h00);
        read_reg("status", SEL_STATUS, 8'h38);
        while (fifo_q.size() > 0) begin
            read_reg("rx_holding", SEL_DATA, fifo_q.pop_front());
        end
        read_reg("status", SEL_STATUS, 8'h30);
        check("irq_n", 8'(irq_n), 8'h01);
        // Transmit interrupt stays off for code 10; code 00 raises RTS.
        transmit_irq_control = 2'h2;
        u_host.access(1'b0, 1'b1, SEL_DATA, 8'($urandom));
        repeat (TX_LAG_CYCLES + 20) @(negedge sys_clk);
        read_reg("status", SEL_STATUS, 8'h20);
        tx_take = 1'b1;
        @(negedge sys_clk);
        tx_take = 1'b0;
        repeat (TX_LAG_CYCLES + 20) @(negedge sys_clk);
        read_reg("status", SEL_STATUS, 8'h30);
        transmit_irq_control = 2'h0;
        repeat (2) @(negedge sys_clk);
        check("rts_n", 8'(request_to_send_n), 8'h01);
        // Carrier changes twice; the second shows only after a status read.
        carrier_detect_n = 1'b0;
        wait_irq(1'b0, 10);
        carrier_detect_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        read_reg("status", SEL_STATUS, 8'h90);
        wait_irq(1'b0, 10);
        read_reg("status", SEL_STATUS, 8'hb0);
        read_reg("status", SEL_STATUS, 8'h30);
        // A hardware reset in mid-run empties the transmit holding register and the receive FIFO.
        u_host.access(1'b0, 1'b1, SEL_DATA, 8'h3c);
        push_rx(8'h5a, 1'b1, 1'b0);
        resetn = 1'b0;
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (5) @(negedge sys_clk);
        check("tx_valid", 8'(tx_valid), 8'h00);
        check("irq_n", 8'(irq_n), 8'h01);
        read_reg("status", SEL_STATUS, 8'h30);
        summarize();
    end
endmodule
`default_nettype wire
